// >>> common/atsm_pkg.sv
package atsm_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SEC_NS        = 1_000_000_000;
  localparam int unsigned SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned IDLE_S        = 10;
  localparam logic [11:0] MAX_SECONDS   = 12'hE10;  // 3600

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] OFS_SP       = 8'h00;  // channel relative
  localparam logic [7:0] OFS_HYS      = 8'h04;
  localparam logic [7:0] OFS_WAIT     = 8'h08;
  localparam logic [7:0] OFS_QUIET    = 8'h0C;
  localparam logic [7:0] OFS_CTRL     = 8'h10;
  localparam logic [7:0] CH_STRIDE    = 8'h20;
  localparam logic [7:0] OFS_DSM      = 8'h40;
  localparam logic [7:0] OFS_CODE     = 8'h44;
  localparam logic [7:0] OFS_STATUS   = 8'h48;
  localparam logic [7:0] OFS_DISP     = 8'h4C;
  localparam int unsigned CTRL_ON     = 0;
  localparam int unsigned CTRL_HIGH   = 1;
  localparam int unsigned CTRL_POL    = 2;
  localparam int unsigned DSM_EN      = 0;
  localparam int unsigned DSM_TOGGLE  = 1;
  localparam logic [15:0] CODE_RESET  = 16'h0000;
  localparam logic        DSM_RESET   = 1'b0;

  typedef enum logic [4:0] {
    M_DISP = 5'h01,
    M_PINP = 5'h02,
    M_PINE = 5'h04,
    M_SPP  = 5'h08,
    M_SPE  = 5'h10
  } atsm_menu_e;

  typedef struct packed {
    logic [15:0] sp;         // bcd
    logic [15:0] hys;        // bcd
    logic [11:0] wait_lim;   // seconds
    logic [11:0] quiet_lim;  // seconds
    logic        on;
    logic        high;
    logic        pol;        // 1: switch closed in alarm
    logic        cond;
    logic [11:0] wait_cnt;
    logic        active;
    logic        silenced;
    logic [11:0] quiet_cnt;
    logic        out;
  } atsm_chan_s;

endpackage

// >>> core/atsm_core.sv
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
module atsm_core #(
  parameter int unsigned TICKS_PER_SEC = atsm_pkg::SEC_CYCLES
) (
  input  wire logic        CLK,          // system clock
  input  wire logic        SRST,         // synchronous reset, high
  input  wire logic [15:0] DISP_VALUE,   // displayed value, four bcd digits
  input  wire logic        BTN_SEL,      // select button pin, high pressed
  input  wire logic        BTN_UP,       // up button pin
  input  wire logic        BTN_DN,       // down button pin
  input  wire logic        BTN_EXIT,     // exit button pin
  input  wire logic [7:0]  ADDR,         // register byte address
  input  wire logic [31:0] WDATA,        // write data
  input  wire logic        WR,           // write strobe
  input  wire logic        RD,           // read strobe
  output logic      [31:0] RDATA,        // read data, cycle after rd
  output logic      [1:0]  ALARM_OUT,    // switch drive, high closed
  output logic      [1:0]  ALARM_IND,    // display alarm indication
  output logic             SHOW_ALARM_ID,// display shows alarm identifier
  output logic      [4:0]  MENU_STATE,   // one-hot menu state
  output logic             SP_SEL,       // selected setpoint, 0 one, 1 two
  output logic      [15:0] EDIT_VALUE,   // value under edit
  output logic      [3:0]  FLASH_DIGIT   // digit currently blanked
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [3:0]                  sync1;   // {exit, dn, up, sel}
    logic [3:0]                  sync2;
    logic [3:0]                  prev;
    logic [31:0]                 presc;
    atsm_pkg::atsm_chan_s [1:0]  chan;
    logic                        dsm_en;
    logic [15:0]                 code;
    atsm_pkg::atsm_menu_e        menu;
    logic [1:0]                  digit;
    logic [15:0]                 buf_v;
    logic                        sp_sel;
    logic [3:0]                  idle;
    logic                        blink;
    logic                        show_id;
    logic [3:0]                  flash;
    logic [31:0]                 rdata;
  } atsm_state_s;

  atsm_state_s r_reg;
  atsm_state_s r_next;

  logic        tick;
  logic [3:0]  press;
  logic        combo;
  logic        accept;
  logic        any_press;
  logic [13:0] val_bin;
  logic [14:0] sp_w;
  logic [14:0] hys_w;
  logic [14:0] val_w;
  logic        set_c;
  logic        clr_c;
  logic        cond_now;
  logic        alarm;
  logic [3:0]  nib;
  logic [7:0]  base;

  // ****************************************
  // helpers
  // ****************************************
  // four bcd digits to binary, used for value, setpoint and hysteresis
  function automatic logic [13:0] bcd2bin(input logic [15:0] b);
    logic [13:0] t;
    t = 14'(b[15:12]) * 14'd1000 + 14'(b[11:8]) * 14'd100 + 14'(b[7:4]) * 14'd10 + 14'(b[3:0]);
    return t;
  endfunction

  // one decimal digit up or down with wrap, so stored bcd stays legal
  function automatic logic [3:0] digit_step(input logic [3:0] d, input logic up);
    logic [3:0] t;
    if (up) begin
      t = (d >= 4'h9) ? 4'h0 : d + 4'h1;
    end else begin
      t = (d == 4'h0 || d > 4'h9) ? 4'h9 : d - 4'h1;
    end
    return t;
  endfunction

  // seconds field limited to the legal range
  function automatic logic [11:0] clamp_s(input logic [31:0] w);
    logic [11:0] t;
    t = (w > 32'(atsm_pkg::MAX_SECONDS)) ? atsm_pkg::MAX_SECONDS : w[11:0];
    return t;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    r_next = r_reg;
    tick      = 1'b0;
    press     = 4'h0;
    combo     = 1'b0;
    accept    = 1'b0;
    any_press = 1'b0;
    val_bin   = 14'h0000;
    sp_w      = 15'h0000;
    hys_w     = 15'h0000;
    val_w     = 15'h0000;
    set_c     = 1'b0;
    clr_c     = 1'b0;
    cond_now  = 1'b0;
    alarm     = 1'b0;
    nib       = 4'h0;
    base      = 8'h00;

    // button pins: first stage is only copied into the second
    r_next.sync1 = {BTN_EXIT, BTN_DN, BTN_UP, BTN_SEL};
    r_next.sync2 = r_reg.sync1;
    r_next.prev  = r_reg.sync2;
    press        = r_reg.sync2 & ~r_reg.prev;
    any_press    = |press;
    // both press orders count as the entry chord
    combo  = (press[0] & r_reg.sync2[1]) | (press[1] & r_reg.sync2[0]);
    accept = press[0] & ~r_reg.sync2[1] & (r_reg.menu == atsm_pkg::M_DISP);

    // one second timebase shared by all timers
    tick         = (r_reg.presc == 32'(TICKS_PER_SEC - 1));
    r_next.presc = tick ? 32'h0000_0000 : r_reg.presc + 32'h0000_0001;

    // register writes; channel fields repeat per channel
    for (int c = 0; c < 2; c++) begin
      base = 8'(c) * atsm_pkg::CH_STRIDE;
      if (WR) begin
        if (ADDR == base + atsm_pkg::OFS_SP)    r_next.chan[c].sp  = WDATA[15:0];
        if (ADDR == base + atsm_pkg::OFS_HYS)   r_next.chan[c].hys = WDATA[15:0];
        if (ADDR == base + atsm_pkg::OFS_WAIT)  r_next.chan[c].wait_lim  = clamp_s(WDATA);
        if (ADDR == base + atsm_pkg::OFS_QUIET) r_next.chan[c].quiet_lim = clamp_s(WDATA);
        if (ADDR == base + atsm_pkg::OFS_CTRL) begin
          r_next.chan[c].on   = WDATA[atsm_pkg::CTRL_ON];
          r_next.chan[c].high = WDATA[atsm_pkg::CTRL_HIGH];
          r_next.chan[c].pol  = WDATA[atsm_pkg::CTRL_POL];
        end
      end
    end
    if (WR && ADDR == atsm_pkg::OFS_DSM) begin
      // toggle bit mirrors the up/down action of the enable item
      r_next.dsm_en = WDATA[atsm_pkg::DSM_TOGGLE] ? ~r_reg.dsm_en : WDATA[atsm_pkg::DSM_EN];
    end
    if (WR && ADDR == atsm_pkg::OFS_CODE) begin
      r_next.code = WDATA[15:0];
    end

    // alarm channels
    val_bin = bcd2bin(DISP_VALUE);
    val_w   = {1'b0, val_bin};
    for (int c = 0; c < 2; c++) begin
      sp_w  = {1'b0, bcd2bin(r_reg.chan[c].sp)};
      hys_w = {1'b0, bcd2bin(r_reg.chan[c].hys)};
      // compare by adding hysteresis, so no subtraction can underflow
      if (r_reg.chan[c].high) begin
        set_c = val_w >= sp_w;
        clr_c = val_w + hys_w < sp_w;
      end else begin
        set_c = val_w <= sp_w;
        clr_c = val_w > sp_w + hys_w;
      end
      cond_now = set_c | (r_reg.chan[c].cond & ~clr_c);
      if (!r_reg.chan[c].on) begin
        // disabled: runtime state dropped, settings untouched
        r_next.chan[c].cond      = 1'b0;
        r_next.chan[c].wait_cnt  = 12'h000;
        r_next.chan[c].active    = 1'b0;
        r_next.chan[c].silenced  = 1'b0;
        r_next.chan[c].quiet_cnt = 12'h000;
      end else if (!cond_now) begin
        r_next.chan[c].cond      = 1'b0;
        r_next.chan[c].wait_cnt  = 12'h000;
        r_next.chan[c].active    = 1'b0;
        r_next.chan[c].silenced  = 1'b0;
        r_next.chan[c].quiet_cnt = 12'h000;
      end else begin
        r_next.chan[c].cond = 1'b1;
        if (!r_reg.chan[c].active) begin
          if (r_reg.chan[c].wait_cnt >= r_reg.chan[c].wait_lim) begin
            r_next.chan[c].active = 1'b1;
          end else if (tick) begin
            r_next.chan[c].wait_cnt = r_reg.chan[c].wait_cnt + 12'h001;
          end
        end else if (!r_reg.chan[c].silenced) begin
          if (accept && r_reg.chan[c].quiet_lim != 12'h000) begin
            r_next.chan[c].silenced  = 1'b1;
            r_next.chan[c].quiet_cnt = r_reg.chan[c].quiet_lim;
          end
        end else if (tick) begin
          // silence ends; output returns since condition still holds
          if (r_reg.chan[c].quiet_cnt <= 12'h001) begin
            r_next.chan[c].silenced = 1'b0;
          end
          r_next.chan[c].quiet_cnt = r_reg.chan[c].quiet_cnt - 12'h001;
        end
      end
      alarm = r_next.chan[c].active & ~r_next.chan[c].silenced;
      r_next.chan[c].out = r_reg.chan[c].pol ? alarm : ~alarm;
    end

    // display alternation while any alarm is active, silenced or not
    if (r_next.chan[0].active | r_next.chan[1].active) begin
      if (tick) begin
        r_next.show_id = ~r_reg.show_id;
      end
    end else begin
      r_next.show_id = 1'b0;
    end
    if (tick) begin
      r_next.blink = ~r_reg.blink;
    end

    // direct setpoint menu
    nib = r_reg.buf_v[{r_reg.digit, 2'b00} +: 4];
    unique case (r_reg.menu)
      atsm_pkg::M_DISP: begin
        r_next.idle = 4'h0;
        if (combo && r_reg.dsm_en) begin
          r_next.sp_sel = 1'b0;
          r_next.menu   = (r_reg.code == 16'h0000) ? atsm_pkg::M_SPP : atsm_pkg::M_PINP;
        end
      end
      atsm_pkg::M_PINP: begin
        if (press[0]) begin
          r_next.menu  = atsm_pkg::M_PINE;
          r_next.buf_v = 16'h0000;
          r_next.digit = 2'h3;
        end else if (press[3]) begin
          r_next.menu = atsm_pkg::M_DISP;
        end
      end
      atsm_pkg::M_PINE, atsm_pkg::M_SPE: begin
        if (press[1] | press[2]) begin
          r_next.buf_v[{r_reg.digit, 2'b00} +: 4] = digit_step(nib, press[1]);
        end else if (press[0]) begin
          r_next.digit = r_reg.digit - 2'h1;
        end else if (press[3]) begin
          if (r_reg.menu == atsm_pkg::M_SPE) begin
            r_next.chan[r_reg.sp_sel].sp = r_reg.buf_v;
            r_next.menu = atsm_pkg::M_SPP;
          end else begin
            r_next.menu = (r_reg.buf_v == r_reg.code) ? atsm_pkg::M_SPP : atsm_pkg::M_DISP;
          end
        end
      end
      atsm_pkg::M_SPP: begin
        if (press[1] | press[2]) begin
          r_next.sp_sel = ~r_reg.sp_sel;
        end else if (press[0]) begin
          r_next.menu  = atsm_pkg::M_SPE;
          r_next.buf_v = r_reg.chan[r_reg.sp_sel].sp;
          r_next.digit = 2'h3;
        end else if (press[3]) begin
          r_next.menu = atsm_pkg::M_DISP;
        end
      end
      default: begin
        r_next.menu = atsm_pkg::M_DISP;
      end
    endcase

    // idle timeout drops the menu without storing anything
    if (r_reg.menu != atsm_pkg::M_DISP) begin
      if (any_press) begin
        r_next.idle = 4'h0;
      end else if (tick) begin
        r_next.idle = r_reg.idle + 4'h1;
        if (r_reg.idle == 4'(atsm_pkg::IDLE_S - 1)) begin
          r_next.menu = atsm_pkg::M_DISP;
        end
      end
    end

    // blank the digit under code entry on alternate seconds
    r_next.flash = (r_next.menu == atsm_pkg::M_PINE && r_next.blink) ? (4'h1 << r_next.digit) : 4'h0;

    // read port: data valid only in the cycle after rd
    r_next.rdata = 32'h0000_0000;
    if (RD) begin
      for (int c = 0; c < 2; c++) begin
        base = 8'(c) * atsm_pkg::CH_STRIDE;
        if (ADDR == base + atsm_pkg::OFS_SP)    r_next.rdata = {16'h0000, r_reg.chan[c].sp};
        if (ADDR == base + atsm_pkg::OFS_HYS)   r_next.rdata = {16'h0000, r_reg.chan[c].hys};
        if (ADDR == base + atsm_pkg::OFS_WAIT)  r_next.rdata = {20'h00000, r_reg.chan[c].wait_lim};
        if (ADDR == base + atsm_pkg::OFS_QUIET) r_next.rdata = {20'h00000, r_reg.chan[c].quiet_lim};
        if (ADDR == base + atsm_pkg::OFS_CTRL) begin
          r_next.rdata = {29'h0, r_reg.chan[c].pol, r_reg.chan[c].high, r_reg.chan[c].on};
        end
      end
      if (ADDR == atsm_pkg::OFS_DSM)  r_next.rdata = {31'h0, r_reg.dsm_en};
      if (ADDR == atsm_pkg::OFS_CODE) r_next.rdata = {16'h0000, r_reg.code};
      if (ADDR == atsm_pkg::OFS_STATUS) begin
        r_next.rdata = {20'h00000, r_reg.sp_sel, r_reg.menu,
                        r_reg.chan[1].out, r_reg.chan[0].out,
                        r_reg.chan[1].silenced, r_reg.chan[0].silenced,
                        r_reg.chan[1].active, r_reg.chan[0].active};
      end
      if (ADDR == atsm_pkg::OFS_DISP) r_next.rdata = {16'h0000, DISP_VALUE};
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge CLK) begin
    if (SRST) begin
      r_reg        <= '0;
      r_reg.menu   <= atsm_pkg::M_DISP;
      r_reg.dsm_en <= atsm_pkg::DSM_RESET;
      r_reg.code   <= atsm_pkg::CODE_RESET;
      r_reg.chan[0].out <= 1'b1;             // pol 0 default: non-alarm is closed
      r_reg.chan[1].out <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from flops
  assign RDATA         = r_reg.rdata;
  assign ALARM_OUT     = {r_reg.chan[1].out, r_reg.chan[0].out};
  assign ALARM_IND     = {r_reg.chan[1].active, r_reg.chan[0].active};
  assign SHOW_ALARM_ID = r_reg.show_id;
  assign MENU_STATE    = r_reg.menu;
  assign SP_SEL        = r_reg.sp_sel;
  assign EDIT_VALUE    = r_reg.buf_v;
  assign FLASH_DIGIT   = r_reg.flash;

endmodule // atsm_core

// >>> verification/atsm_props.sv
`timescale 1ns/1ps
module atsm_props #(
  parameter int unsigned TICKS_PER_SEC = 20  // cycles per timebase tick
) (
  input wire logic        CLK,           // system clock
  input wire logic        SRST,          // sync reset
  input wire logic [15:0] DISP_VALUE,    // displayed value
  input wire logic        BTN_SEL,       // select pin
  input wire logic        BTN_UP,        // up pin
  input wire logic        BTN_DN,        // down pin
  input wire logic        BTN_EXIT,      // exit pin
  input wire logic [7:0]  ADDR,          // address
  input wire logic [31:0] WDATA,         // write data
  input wire logic        WR,            // write strobe
  input wire logic        RD,            // read strobe
  input wire logic [31:0] RDATA,         // read data
  input wire logic [1:0]  ALARM_OUT,     // switch drive
  input wire logic [1:0]  ALARM_IND,     // alarm shown
  input wire logic        SHOW_ALARM_ID, // identifier phase
  input wire logic [4:0]  MENU_STATE,    // menu state
  input wire logic        SP_SEL,        // setpoint choice
  input wire logic [15:0] EDIT_VALUE,    // edit buffer
  input wire logic [3:0]  FLASH_DIGIT    // blanked digit
);
  localparam int LIM_SHOW = TICKS_PER_SEC + 2;
  localparam int LIM_IDLE = 10 * TICKS_PER_SEC + 4;
  logic [1:0] pol_reg;
  logic       dsm_reg;
  int         show_reg;
  int         idle_reg;
  // ****
  // shadows and watchdogs
  // ****
  // polarity and menu enable mirror bus writes; counters time a stuck blink or idle menu
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pol_reg  <= 2'h0;
      dsm_reg  <= 1'b0;
      show_reg <= 0;
      idle_reg <= 0;
    end else begin
      if (WR && ADDR == 8'h10) pol_reg[0] <= WDATA[2];
      if (WR && ADDR == 8'h30) pol_reg[1] <= WDATA[2];
      if (WR && ADDR == 8'h40) dsm_reg <= WDATA[1] ? !dsm_reg : WDATA[0];
      show_reg <= (ALARM_IND == 2'h0 || $changed(SHOW_ALARM_ID)) ? 0 : show_reg + 1;
      idle_reg <= (MENU_STATE == 5'h01 || BTN_SEL || BTN_UP || BTN_DN || BTN_EXIT) ? 0 : idle_reg + 1;
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // polarity guard skips the cycles where a new polarity is still landing
  a_out_rest_level:
    assert property (pol_reg == $past(pol_reg) && pol_reg == $past(pol_reg, 2)
      |-> ((~ALARM_IND) & (ALARM_OUT ^ ~pol_reg)) == 2'h0) else $error("idle channel off rest level");
  a_show_rest:
    assert property (ALARM_IND == 2'h0 && $past(ALARM_IND) == 2'h0 && $past(ALARM_IND, 2) == 2'h0
      |-> !SHOW_ALARM_ID) else $error("identifier without alarm");
  a_show_blink:
    assert property (show_reg <= LIM_SHOW) else $error("identifier phase stuck");
  a_menu_onehot:
    assert property ($onehot(MENU_STATE)) else $error("menu state not one-hot");
  a_flash_edit:
    assert property (FLASH_DIGIT != 4'h0 |-> MENU_STATE == 5'h04 && $onehot(FLASH_DIGIT))
      else $error("flash outside code edit");
  a_menu_locked:
    assert property (MENU_STATE == 5'h01 && !dsm_reg |=> MENU_STATE == 5'h01) else $error("menu opened while off");
  a_entry_first_sp:
    assert property ($rose(MENU_STATE == 5'h08) && $past(MENU_STATE) != 5'h10 |-> !SP_SEL)
      else $error("entry not on setpoint one");
  a_code_exit:
    assert property ($past(MENU_STATE) == 5'h04 && MENU_STATE != 5'h04 |-> MENU_STATE inside {5'h01, 5'h08})
      else $error("code edit left to wrong state");
  a_idle_limit:
    assert property (idle_reg <= LIM_IDLE) else $error("idle menu not closed");
  c_sp_prompt: cover property ($rose(MENU_STATE == 5'h08));
  c_silenced: cover property (ALARM_IND[0] && ALARM_OUT[0]);
  c_flash: cover property (FLASH_DIGIT == 4'h8);
endmodule // atsm_props
bind atsm_core atsm_props #(.TICKS_PER_SEC(TICKS_PER_SEC)) atsm_props_inst (
  .CLK(CLK), .SRST(SRST), .DISP_VALUE(DISP_VALUE), .BTN_SEL(BTN_SEL), .BTN_UP(BTN_UP), .BTN_DN(BTN_DN),
  .BTN_EXIT(BTN_EXIT), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .ALARM_OUT(ALARM_OUT),
  .ALARM_IND(ALARM_IND), .SHOW_ALARM_ID(SHOW_ALARM_ID), .MENU_STATE(MENU_STATE), .SP_SEL(SP_SEL),
  .EDIT_VALUE(EDIT_VALUE), .FLASH_DIGIT(FLASH_DIGIT));

// >>> verification/atsm_panel.sv
`timescale 1ns/1ps
module atsm_panel (
  input  wire logic       clk,  // system clock
  input  wire logic       rst,  // sync reset
  input  wire logic       go,   // start one press
  input  wire logic [3:0] keys, // {exit, dn, up, sel}
  output logic            busy, // press under way
  output logic      [3:0] btn   // pins, high pressed
);
  logic [5:0] cnt_reg;
  // one press: held 16 cycles, then released 16 so the next edge is clean
  always_ff @(posedge clk) begin
    if (rst) begin
      busy    <= 1'b0;
      cnt_reg <= 6'h00;
    end else if (go && !busy) begin
      busy    <= 1'b1;
      cnt_reg <= 6'h00;
    end else if (busy) begin
      cnt_reg <= cnt_reg + 6'h01;
      busy    <= cnt_reg != 6'h1F;
    end
  end
  // select of a chord trails up, so the block sees select rise with up held
  always_comb begin
    btn = (busy && cnt_reg < 6'h10) ? keys : 4'h0;
    if (keys[1:0] == 2'h3 && cnt_reg < 6'h04) btn[0] = 1'b0;
  end
endmodule // atsm_panel

// >>> verification/atsm_tb.sv
`timescale 1ns/1ps
module testbench;
  localparam int T = 20;  // short second keeps the run brief
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [15:0] disp = 16'h0000;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        go = 1'b0;
  logic [3:0]  keys = 4'h0;
  logic [3:0]  btn;
  logic        busy;
  logic [31:0] rdata;
  logic [1:0]  aout;
  logic [1:0]  aind;
  logic        show_id;
  logic [4:0]  menu;
  logic        sp_sel;
  logic [15:0] edit;
  logic [3:0]  flash;
  logic        s;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  atsm_core #(.TICKS_PER_SEC(T)) atsm_core_inst (
    .CLK(clk), .SRST(srst), .DISP_VALUE(disp), .BTN_SEL(btn[0]), .BTN_UP(btn[1]), .BTN_DN(btn[2]),
    .BTN_EXIT(btn[3]), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .ALARM_OUT(aout),
    .ALARM_IND(aind), .SHOW_ALARM_ID(show_id), .MENU_STATE(menu), .SP_SEL(sp_sel), .EDIT_VALUE(edit),
    .FLASH_DIGIT(flash));
  atsm_panel atsm_panel_inst (.clk(clk), .rst(srst), .go(go), .keys(keys), .busy(busy), .btn(btn));
  // ****
  // helpers
  // ****
  initial forever #2 clk = ~clk;
  // hang guard: the whole run needs only a few thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe edge
  task automatic rreg(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, rdata, e);
  endtask
  task automatic press(input logic [3:0] k);
    @(posedge clk);
    keys <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (int i = 0; i < 64 && busy !== 1'b0; i++) #4;
    @(posedge clk);
    keys <= 4'h0;
    // step off the edge so callers compare settled outputs
    #1;
  endtask
  task automatic step(input logic [15:0] v, input logic [1:0] ind, input logic [1:0] out);
    @(posedge clk);
    disp <= v;
    cyc(4);
    #1;
    chk("alarm_ind", aind, ind);
    chk("alarm_out", aout, out);
  endtask
  task automatic setup(input logic [7:0] b, input logic [15:0] sp, input logic [11:0] w, input logic [2:0] c);
    wreg(b, {16'h0, sp});
    wreg(b + 8'h04, 32'h0010);
    wreg(b + 8'h08, {20'h0, w});
    wreg(b + 8'h0C, 32'h0);
    wreg(b + 8'h10, {29'h0, c});
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_alarm();
    rreg("menu_enable", 8'h40, 32'h0);
    rreg("access_code", 8'h44, 32'h0);
    rreg("unmapped", 8'h80, 32'h0);
    setup(8'h00, 16'h0240, 12'h0, 3'h3);
    step(16'h0239, 2'h0, 2'h3);
    step(16'h0240, 2'h1, 2'h2);
    rreg("status", 8'h48, 32'h61);
    step(16'h0230, 2'h1, 2'h2);
    step(16'h0229, 2'h0, 2'h3);
    setup(8'h20, 16'h0100, 12'h0, 3'h5);
    step(16'h0111, 2'h0, 2'h1);
    step(16'h0100, 2'h2, 2'h3);
    step(16'h0110, 2'h2, 2'h3);
    wreg(8'h30, 32'h4);
    step(16'h0100, 2'h0, 2'h1);
    wreg(8'h30, 32'h5);
    step(16'h0100, 2'h2, 2'h3);
    wreg(8'h30, 32'h4);
  endtask
  task automatic t_wait();
    setup(8'h00, 16'h0240, 12'h3, 3'h3);
    step(16'h0250, 2'h0, 2'h1);
    cyc(30);
    step(16'h0229, 2'h0, 2'h1);
    step(16'h0250, 2'h0, 2'h1);
    cyc(31);
    #1 chk("wait_restart", aind, 2'h0);
    for (int i = 0; i < 2 * T + 8 && aind[0] !== 1'b1; i++) @(posedge clk);
    #1 chk("wait_done", aout, 2'h0);
    wreg(8'h08, 32'd4000);
    rreg("wait_clamp", 8'h08, 32'hE10);
    wreg(8'h08, 32'h0);
  endtask
  task automatic t_quiet();
    press(4'h1);
    chk("no_accept", aout[0], 1'b0);
    wreg(8'h0C, 32'd4000);
    rreg("quiet_clamp", 8'h0C, 32'hE10);
    wreg(8'h0C, 32'h4);
    press(4'h1);
    chk("silenced_out", aout[0], 1'b1);
    chk("silenced_ind", aind[0], 1'b1);
    s = show_id;
    for (int i = 0; i < T + 4 && show_id === s; i++) @(posedge clk);
    #1 chk("id_blink", show_id, !s);
    for (int i = 0; i < 5 * T && aout[0] !== 1'b0; i++) @(posedge clk);
    #1 chk("restored", aout[0], 1'b0);
    step(16'h0229, 2'h0, 2'h1);
  endtask
  task automatic t_menu();
    press(4'h3);
    chk("refused", menu, 5'h01);
    wreg(8'h40, 32'h2);
    rreg("toggle_on", 8'h40, 32'h1);
    wreg(8'h40, 32'h2);
    rreg("toggle_off", 8'h40, 32'h0);
    wreg(8'h40, 32'h1);
    press(4'h3);
    chk("direct", menu, 5'h08);
    press(4'h2);
    chk("sp_two", sp_sel, 1'b1);
    press(4'h4);
    chk("sp_one", sp_sel, 1'b0);
    press(4'h1);
    chk("edit_load", edit, 16'h0240);
    press(4'h2);
    press(4'h1);
    press(4'h4);
    chk("edit_digits", edit, 16'h1140);
    press(4'h8);
    chk("prompt", menu, 5'h08);
    rreg("stored", 8'h00, 32'h1140);
    press(4'h8);
    chk("display", menu, 5'h01);
  endtask
  task automatic t_code();
    wreg(8'h44, 32'h0001);
    rreg("code", 8'h44, 32'h0001);
    press(4'h3);
    chk("code_prompt", menu, 5'h02);
    press(4'h1);
    for (int i = 0; i < 2 * T + 4 && flash !== 4'h8; i++) begin
      @(posedge clk);
      #1;
    end
    chk("flash", flash, 4'h8);
    repeat (3) press(4'h1);
    press(4'h2);
    chk("code_edit", edit, 16'h0001);
    press(4'h8);
    chk("code_ok", menu, 5'h08);
    press(4'h8);
    press(4'h3);
    press(4'h1);
    press(4'h8);
    chk("code_bad", menu, 5'h01);
    press(4'h3);
    // the exit may come after only nine seconds, so look well before that
    cyc(7 * T);
    #1 chk("idle_early", menu, 5'h02);
    for (int i = 0; i < 3 * T + 8 && menu !== 5'h01; i++) @(posedge clk);
    #1 chk("idle_exit", menu, 5'h01);
  endtask
  // reset, then every scenario in turn
  initial begin
    cyc(16);
    srst <= 1'b0;
    cyc(2);
    t_alarm();
    t_wait();
    t_quiet();
    t_menu();
    t_code();
    summarize();
  end
endmodule // testbench
